// ===== logic/fac_params.svh
// Timing and field constants for the asynchronous memory port controller.
// ==========================================================================
// How it works
// R1: Wait 1 ms after power-up before access.
// R2: Power may drop once write strobe is high.
// R3: Sleep input ignores chip select immediately.
// R4: Data lines float within 20 ns of sleep.
// R5: Sleep may follow last write with no gap.
// R6: Sleep low 1 us; wait 450 us after wake.
// R7: Write data latched on first rising strobe.
// R8: Strobe-started write reads first, latches upper address.
// R9: Hold low address bits 15 ns in page mode.
// R10: Read needs output enable low, lanes selected.
// R11: Write touches only selected byte lanes.
// R12: Selects tie low only without byte writes.
// R13: Low-bit address change gives page read.
// R14: Same upper address, strobe fall: page write.
// R15: Rising chip select pre-charges; high means standby.
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH

// ==========================================================================
// Clock and bus geometry.
`define FAC_CLK_PS 8000
`define FAC_AW 17
`define FAC_DW 16
`define FAC_TW 17
`define FAC_PAGE_LSB 2

// ==========================================================================
// Times in nanoseconds, the slow supply column where two are given.
`define FAC_PU_NS 1000000
`define FAC_ZZL_NS 1000
`define FAC_ZZEX_NS 450000
`define FAC_RD_NS 105
`define FAC_WC_NS 105
`define FAC_PRD_NS 40
`define FAC_WP_NS 22
`define FAC_PWC_NS 40
`define FAC_PC_NS 35
`define FAC_A10_NS 15

// ==========================================================================
// Reset values and limits.
`define FAC_CNT_ZERO 17'h00000
`define FAC_CNT_MAX 17'h1ffff
`define FAC_DATA_ZERO 16'h0000
`define FAC_SEL_OFF 2'h3

`endif

// ===== logic/fac_pkg.sv
// Types and cycle arithmetic shared by the memory port controller.
`include "fac_params.svh"

package fac_pkg;

	// ==================================================================
	// Request held by the controller: direction, address, data, lanes.
	typedef struct packed {
		logic write; // High for a write.
		logic [`FAC_AW-1:0] addr; // Word address.
		logic [`FAC_DW-1:0] wdata; // Write data.
		logic [1:0] be_n; // Lane selects, bit 1 upper, active low.
	} fac_req_t;

	// Strobe and address pins toward the memory.
	typedef struct packed {
		logic ce_n; // Chip select, active low.
		logic we_n; // Write strobe, active low.
		logic oe_n; // Output enable, active low.
		logic upper_byte_sel_n; // Upper lane select.
		logic lower_byte_sel_n; // Lower lane select.
		logic sleep_request_n; // Sleep request, active low.
		logic [`FAC_AW-1:0] addr; // Address pins.
	} fac_pins_t;

	// Controller states.
	typedef enum logic [2:0] {
		FAC_PWRUP, FAC_IDLE, FAC_ACC, FAC_GAP,
		FAC_OPEN, FAC_PRECH, FAC_SLEEP, FAC_WAKE
	} fac_state_t;

	// ==================================================================
	// Least time in ns to whole clock cycles, rounded up, at least one.
	function automatic int fac_cyc_up(input int ns);
		int c;
		c = (ns * 1000 + `FAC_CLK_PS - 1) / `FAC_CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction : fac_cyc_up

	// Timer load value so that a state lasts the given least time.
	function automatic logic [`FAC_TW-1:0] fac_tval(input int ns);
		return `FAC_TW'(fac_cyc_up(ns) - 1);
	endfunction : fac_tval

endpackage : fac_pkg

// ===== logic/fac_timer.sv
// Down-counter that times all states of the memory port controller but idle and open.
`timescale 1ns/10ps
`include "fac_params.svh"

module fac_timer #(
	parameter logic [`FAC_TW-1:0] RST_VAL = `FAC_CNT_ZERO
) (
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Load request and value.
	input wire logic load_in,
	input wire logic [`FAC_TW-1:0] val_in,
	// Expiry.
	output logic done_out
);
	import fac_pkg::*;

	logic [`FAC_TW-1:0] cnt; // Cycles still to run.

	// ==================================================================
	// Count down to zero; a load restarts the count.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt <= RST_VAL;
		end else if (ce_in) begin
			if (load_in) begin
				cnt <= val_in;
			end else if (cnt != `FAC_CNT_ZERO) begin
				cnt <= cnt - `FAC_TW'(1);
			end
		end
	end

	// Zero means the state has lasted its time.
	assign done_out = (cnt == `FAC_CNT_ZERO);

endmodule : fac_timer

// ===== logic/fac_ctrl.sv
// Host controller driving an asynchronous nonvolatile memory port.
`timescale 1ns/10ps
`include "fac_params.svh"

module fac_ctrl #(
	parameter int unsigned PWRUP_CYC = fac_pkg::fac_cyc_up(`FAC_PU_NS),
	parameter int unsigned WAKE_CYC = fac_pkg::fac_cyc_up(`FAC_ZZEX_NS)
) (
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// User request side.
	input wire logic req_valid_in,
	input wire fac_pkg::fac_req_t req_in,
	output logic req_ready_out,
	output logic [`FAC_DW-1:0] rdata_out,
	output logic rvalid_out,
	// User power control.
	input wire logic sleep_req_in,
	output logic asleep_out,
	output logic pwr_off_ok_out,
	// Memory pins.
	output fac_pkg::fac_pins_t mem_out,
	input wire logic [`FAC_DW-1:0] dq_in,
	output logic [`FAC_DW-1:0] dq_out,
	output logic dq_oe_out
);
	import fac_pkg::*;

	localparam int ZZL_CYC = fac_cyc_up(`FAC_ZZL_NS); // Least sleep.
	localparam int A10_CYC = fac_cyc_up(`FAC_A10_NS); // Low bits hold.

	fac_state_t state; // Present state.
	fac_state_t next_state; // State after this edge.
	fac_req_t cur; // Request being served.
	fac_req_t next_cur; // Request served after this edge.
	logic pend; // A taken request waits behind a pre-charge.
	logic next_pend; // Pending flag after this edge.
	logic tld; // Restart the timer.
	logic [`FAC_TW-1:0] tval; // Timer restart value.
	logic tdone; // Timer expired.
	logic take; // A user request is taken this cycle.
	logic same_row; // Upper address matches the open row.
	// ==================================================================
	// State timer; its reset value is the power-up wait.
	fac_timer #(
		.RST_VAL(`FAC_TW'(PWRUP_CYC))
	) u_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.load_in(tld),
		.val_in(tval),
		.done_out(tdone)
	);

	assign take = req_valid_in & req_ready_out;
	assign same_row = req_in.addr[`FAC_AW-1:`FAC_PAGE_LSB] ==
		cur.addr[`FAC_AW-1:`FAC_PAGE_LSB];
	// ==================================================================
	// Next state, held request and timer reload.
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_pend = pend;
		tld = 1'b0;
		tval = `FAC_CNT_ZERO;
		unique case (state)
			FAC_PWRUP: begin
				// No access until the supply has settled. [R1]
				if (tdone) begin
					next_state = FAC_IDLE;
				end
			end
			FAC_IDLE: begin
				if (take) begin
					// Fresh row: full random cycle time.
					next_state = FAC_ACC;
					next_cur = req_in;
					tld = 1'b1;
					tval = req_in.write ? fac_tval(`FAC_WC_NS) :
						fac_tval(`FAC_RD_NS);
				end else if (sleep_req_in) begin
					// A taken request is never dropped; sleep waits.
					next_state = FAC_SLEEP;
					tld = 1'b1;
					tval = fac_tval(`FAC_ZZL_NS);
				end
			end
			FAC_ACC: begin
				if (tdone) begin
					next_state = cur.write ? FAC_GAP : FAC_OPEN;
					tld = cur.write;
					tval = fac_tval(`FAC_PWC_NS - `FAC_WP_NS);
				end
			end
			FAC_GAP: begin
				// Strobe stays high long enough for the page cycle.
				if (tdone) begin
					next_state = FAC_OPEN;
				end
			end
			FAC_OPEN: begin
				if (take && same_row) begin
					// Row stays open: short page access.
					next_state = FAC_ACC;
					next_cur = req_in;
					tld = 1'b1;
					tval = req_in.write ? fac_tval(`FAC_WP_NS) :
						fac_tval(`FAC_PRD_NS);
				end else if (take) begin
					// New row: close the old one first.
					next_state = FAC_PRECH;
					next_cur = req_in;
					next_pend = 1'b1;
					tld = 1'b1;
					tval = fac_tval(`FAC_PC_NS);
				end else if (sleep_req_in) begin
					// Sleep after the last write still goes through a pre-charge first. [R5]
					next_state = FAC_PRECH;
					tld = 1'b1;
					tval = fac_tval(`FAC_PC_NS);
				end
			end
			FAC_PRECH: begin
				if (tdone && pend) begin
					next_state = FAC_ACC;
					next_pend = 1'b0;
					tld = 1'b1;
					tval = cur.write ? fac_tval(`FAC_WC_NS) :
						fac_tval(`FAC_RD_NS);
				end else if (tdone && sleep_req_in) begin
					next_state = FAC_SLEEP;
					tld = 1'b1;
					tval = fac_tval(`FAC_ZZL_NS);
				end else if (tdone) begin
					next_state = FAC_IDLE;
				end
			end
			FAC_SLEEP: begin
				// Least low time is kept even if the user lets go. [R6]
				if (tdone && !sleep_req_in) begin
					next_state = FAC_WAKE;
					tld = 1'b1;
					tval = `FAC_TW'(WAKE_CYC - 1);
				end
			end
			FAC_WAKE: begin
				// Full wake-up time before any access. [R6]
				if (tdone) begin
					next_state = FAC_IDLE;
				end
			end
		endcase
	end
	// ==================================================================
	// State, request and pending flag.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= FAC_PWRUP;
			cur <= '0;
			pend <= 1'b0;
		end else if (ce_in) begin
			state <= next_state;
			cur <= next_cur;
			pend <= next_pend;
		end
	end
	// ==================================================================
	// Pins follow the next state so every pin leaves a flip-flop.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mem_out <= {1'b1, 1'b1, 1'b1, `FAC_SEL_OFF, 1'b1, `FAC_AW'(0)};
			dq_out <= `FAC_DATA_ZERO;
			dq_oe_out <= 1'b0;
		end else if (ce_in) begin
			mem_out.sleep_request_n <= next_state != FAC_SLEEP;
			mem_out.addr <= next_cur.addr;
			dq_out <= next_cur.wdata;
			if (next_state == FAC_ACC) begin
				// Lanes come from the request, never tied. [R12]
				mem_out.ce_n <= 1'b0;
				mem_out.we_n <= !next_cur.write;
				mem_out.oe_n <= next_cur.write;
				{mem_out.upper_byte_sel_n, mem_out.lower_byte_sel_n}
					<= next_cur.be_n;
				dq_oe_out <= next_cur.write;
			end else begin
				// Chip select only stays low while the row is open.
				mem_out.ce_n <= !(next_state == FAC_GAP ||
					next_state == FAC_OPEN);
				mem_out.we_n <= 1'b1;
				mem_out.oe_n <= 1'b1;
				{mem_out.upper_byte_sel_n, mem_out.lower_byte_sel_n}
					<= `FAC_SEL_OFF;
				dq_oe_out <= 1'b0;
			end
		end
	end
	// ==================================================================
	// User answers: ready, read data and power status.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			req_ready_out <= 1'b0;
			rdata_out <= `FAC_DATA_ZERO;
			rvalid_out <= 1'b0;
			asleep_out <= 1'b0;
			pwr_off_ok_out <= 1'b0;
		end else if (ce_in) begin
			req_ready_out <= (next_state == FAC_IDLE ||
				next_state == FAC_OPEN) && !sleep_req_in;
			rvalid_out <= state == FAC_ACC && tdone && !cur.write;
			if (state == FAC_ACC && tdone && !cur.write) begin
				rdata_out <= dq_in;
			end
			asleep_out <= next_state == FAC_SLEEP;
			// Supply may drop once the strobe is high again. [R2]
			pwr_off_ok_out <= next_state != FAC_PWRUP &&
				!(next_state == FAC_ACC && next_cur.write);
		end
	end
	// ==================================================================
	// Helper counters read only by the checks below.
	logic [`FAC_TW-1:0] up_cnt; // Cycles since reset.
	logic [`FAC_TW-1:0] zz_cnt; // Cycles with sleep low.
	logic [`FAC_TW-1:0] wk_cnt; // Cycles since sleep released.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			up_cnt <= `FAC_CNT_ZERO;
			zz_cnt <= `FAC_CNT_ZERO;
			wk_cnt <= `FAC_CNT_MAX;
		end else if (ce_in) begin
			if (up_cnt != `FAC_CNT_MAX) begin
				up_cnt <= up_cnt + `FAC_TW'(1);
			end
			zz_cnt <= mem_out.sleep_request_n ? `FAC_CNT_ZERO :
				zz_cnt + `FAC_TW'(1);
			if (!mem_out.sleep_request_n) begin
				wk_cnt <= `FAC_CNT_ZERO;
			end else if (wk_cnt != `FAC_CNT_MAX) begin
				wk_cnt <= wk_cnt + `FAC_TW'(1);
			end
		end
	end
	property p_pwrup_wait;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(mem_out.ce_n) |-> up_cnt >= PWRUP_CYC;
	endproperty
	a_pwrup_wait: assert property (p_pwrup_wait) // [R1]
		else $error("Access started before power-up wait.");
	property p_pwr_off;
		@(posedge clk_in) disable iff (sys_rst_in)
		pwr_off_ok_out |-> mem_out.we_n;
	endproperty
	a_pwr_off: assert property (p_pwr_off) // [R2]
		else $error("Power-off flagged while write strobe low.");
	property p_sleep_entry;
		@(posedge clk_in) disable iff (sys_rst_in)
		!mem_out.sleep_request_n |-> mem_out.ce_n && mem_out.we_n &&
			!dq_oe_out;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) // [R5]
		else $error("Strobes or data active during sleep.");
	property p_sleep_len;
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(mem_out.sleep_request_n) |-> $past(zz_cnt) >= ZZL_CYC - 1;
	endproperty
	a_sleep_len: assert property (p_sleep_len) // [R6]
		else $error("Sleep request held low too briefly.");
	property p_wake_wait;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(mem_out.ce_n) |-> wk_cnt >= WAKE_CYC;
	endproperty
	a_wake_wait: assert property (p_wake_wait) // [R6]
		else $error("Access started before wake-up time.");
	property p_page_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		!mem_out.ce_n && !$past(mem_out.ce_n) &&
			$changed(mem_out.addr[1:0]) |=>
			$stable(mem_out.addr[1:0]) || A10_CYC < 2;
	endproperty
	a_page_hold: assert property (p_page_hold) // [R9]
		else $error("Low address bits changed too soon.");
	property p_lanes;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(mem_out.we_n) |-> {mem_out.upper_byte_sel_n,
			mem_out.lower_byte_sel_n} == cur.be_n && dq_oe_out;
	endproperty
	a_lanes: assert property (p_lanes) // [R12]
		else $error("Write lanes differ from request.");
	property p_page_row;
		@(posedge clk_in) disable iff (sys_rst_in)
		!mem_out.ce_n && !$past(mem_out.ce_n) |->
			$stable(mem_out.addr[`FAC_AW-1:`FAC_PAGE_LSB]);
	endproperty
	a_page_row: assert property (p_page_row) // [R9]
		else $error("Upper address changed while row open.");
endmodule : fac_ctrl

// ===== verif/fac_mem_model.sv
// Behavioural model of the asynchronous nonvolatile memory behind the port.
`timescale 1ns/10ps
`include "fac_params.svh"

module fac_mem_model #(
	parameter int unsigned PU_CYC = 20,
	parameter int unsigned WK_CYC = 30
) (
	// Clock and reset, used to sample the pins and time the host waits.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Pins from the controller.
	input wire fac_pkg::fac_pins_t mem_in,
	input wire logic [15:0] dq_in,
	// Read data and the count of host faults seen.
	output logic [15:0] dq_out,
	output int unsigned err_out
);
	import fac_pkg::*;

	// ==================================================================
	// Storage and decode.
	logic [15:0] mem [0:131071]; // Word array.
	logic [15:0] last = 16'h5a5a; // Last bus value, for the release pattern.
	logic [16:0] wa; // Write address taken at the falling strobe.
	logic [15:0] wd; // Data as it stood before the rising strobe.
	logic [1:0] wsel; // Lane selects before the rising strobe.
	logic wr_q, ce_q, zz_q; // Previous pin states.
	logic awake, rd_en, wr_act;
	int unsigned cyc, zz_cyc, wk_cyc; // Host wait counters.
	assign awake = mem_in.sleep_request_n;
	// Chip select high leaves the port in standby.
	assign rd_en = awake && !mem_in.ce_n && mem_in.we_n && !mem_in.oe_n;
	assign wr_act = awake && !mem_in.ce_n && !mem_in.we_n;

	// Released lanes show a pattern that flips every cycle, not old data.
	always_comb begin
		dq_out = ~last;
		if (rd_en && !mem_in.lower_byte_sel_n) begin
			dq_out[7:0] = mem[mem_in.addr][7:0];
		end
		if (rd_en && !mem_in.upper_byte_sel_n) begin
			dq_out[15:8] = mem[mem_in.addr][15:8];
		end
	end

	// Writes land when the strobe pair ends; faults of the host counted.
	always_ff @(posedge clk_in) begin
		last <= dq_out;
		wr_q <= wr_act;
		ce_q <= mem_in.ce_n;
		zz_q <= awake;
		if (wr_act && !wr_q) begin
			wa <= mem_in.addr;
		end
		if (wr_act) begin
			wd <= dq_in;
			wsel <= {mem_in.upper_byte_sel_n, mem_in.lower_byte_sel_n};
		end
		if (!wr_act && wr_q && !wsel[0]) begin
			mem[wa][7:0] <= wd[7:0];
		end
		if (!wr_act && wr_q && !wsel[1]) begin
			mem[wa][15:8] <= wd[15:8];
		end
		if (sys_rst_in) begin
			cyc <= 0;
			zz_cyc <= 0;
			wk_cyc <= WK_CYC;
			err_out <= 0;
		end else begin
			cyc <= cyc + 1;
			wk_cyc <= wk_cyc + 1;
			zz_cyc <= awake ? 0 : zz_cyc + 1;
			// Page writes must keep the low bits still under the strobe.
			if (wr_act && wr_q && mem_in.addr[1:0] != wa[1:0]) begin
				err_out <= err_out + 1;
			end
			// Sleep shorter than one microsecond (125 cycles).
			if (awake && !zz_q && zz_cyc < 125) begin
				err_out <= err_out + 1;
			end
			if (awake && !zz_q) begin
				wk_cyc <= 0;
			end
			// No access before power-up or wake-up waits are over.
			if (!mem_in.ce_n && ce_q && (cyc < PU_CYC || wk_cyc < WK_CYC)) begin
				err_out <= err_out + 1;
			end
		end
	end
endmodule : fac_mem_model

// ===== verif/testbench.sv
// Self-checking bench of the memory port controller against the model.
`timescale 1ns/10ps

module testbench;
	import fac_pkg::*;

	// ==================================================================
	// Signals.
	logic clk_in = 0, sys_rst_in = 1, req_valid_in = 0, sleep_req_in = 0;
	logic ce_in = 1; // Clock enable, dropped by the freeze test.
	fac_req_t req = '0;
	logic req_ready_out, rvalid_out, asleep_out, pwr_off_ok_out, dq_oe_out;
	logic [15:0] rdata_out, dq_in, dq_out, rd;
	fac_pins_t mem_out;
	int unsigned err;
	int mismatches = 0, n_tests = 0, lr, lp;

	fac_ctrl #(.PWRUP_CYC(20), .WAKE_CYC(30)) u_fac_ctrl (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
		.req_in(req), .req_ready_out(req_ready_out), .rdata_out(rdata_out),
		.rvalid_out(rvalid_out), .sleep_req_in(sleep_req_in),
		.asleep_out(asleep_out), .pwr_off_ok_out(pwr_off_ok_out),
		.mem_out(mem_out), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_out(dq_oe_out));
	fac_mem_model #(.PU_CYC(20), .WK_CYC(30)) u_fac_mem_model (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mem_in(mem_out),
		.dq_in(dq_out), .dq_out(dq_in), .err_out(err));

	// ==================================================================
	// Helpers; all driving happens at the falling edge.
	initial begin
		forever #4 clk_in = ~clk_in;
	end

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Wait for a level on a flag, a bounded number of cycles.
	task automatic wait_hi(input string nm, ref logic f);
		int n;
		n = 0;
		while (f !== 1'b1 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		chk(nm, 1, n < 2000);
	endtask : wait_hi

	// One request; read data and latency in cycles come back.
	task automatic xfer(input logic w, input logic [16:0] a,
		input logic [15:0] d, input logic [1:0] be, output int lat);
		// Let an edge pass so valid never drops and rises in one step.
		@(negedge clk_in);
		req = '{write: w, addr: a, wdata: d, be_n: be};
		req_valid_in = 1;
		wait_hi("ready", req_ready_out);
		@(negedge clk_in);
		req_valid_in = 0;
		lat = 1;
		while (!w && rvalid_out !== 1'b1 && lat < 100) begin
			@(negedge clk_in);
			lat++;
		end
		rd = rdata_out;
	endtask : xfer

	task automatic close_out;
		$display("n_tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	// ==================================================================
	// Scenarios.
	task automatic t_reset;
		chk("ce_n", 1, mem_out.ce_n);
		chk("we_n", 1, mem_out.we_n);
		chk("ready", 0, req_ready_out);
		chk("pwr_ok", 0, pwr_off_ok_out);
		$display("done reset");
	endtask : t_reset

	// Row written, another row opened, then the first row read back:
	// the first read is random after a pre-charge, the others page reads.
	task automatic t_page;
		for (int i = 0; i < 4; i++) xfer(1, 17'h00120 + i, 16'h1000 * i + 7,
			2'h0, lp);
		chk("pwr_busy", 0, pwr_off_ok_out);
		wait_hi("pwr_ok", pwr_off_ok_out);
		chk("we_hi", 1, mem_out.we_n);
		xfer(1, 17'h1f3e0, 16'hbeef, 2'h0, lp);
		xfer(0, 17'h00120, 16'h0, 2'h0, lr);
		chk("rd0", 16'h0007, rd);
		for (int i = 1; i < 4; i++) begin
			xfer(0, 17'h00120 + i, 16'h0, 2'h0, lp);
			chk("rdp", 16'h1000 * i + 7, rd);
		end
		chk("page_fast", 1, lp < lr);
		$display("done page");
	endtask : t_page

	task automatic t_bytes;
		xfer(1, 17'h00121, 16'haaaa, 2'h2, lp);
		xfer(1, 17'h00121, 16'h5555, 2'h1, lp);
		xfer(0, 17'h00121, 16'h0, 2'h0, lp);
		chk("both", 16'h55aa, rd);
		xfer(0, 17'h00121, 16'h0, 2'h2, lp);
		chk("lower", 16'h00aa, rd & 16'h00ff);
		$display("done bytes");
	endtask : t_bytes

	// Row change both ways forces pre-charge and a fresh random read.
	task automatic t_rows;
		xfer(1, 17'h1f3e0, 16'hbeef, 2'h0, lp);
		xfer(0, 17'h00122, 16'h0, 2'h0, lp);
		chk("row_a", 16'h2007, rd);
		xfer(0, 17'h1f3e0, 16'h0, 2'h0, lp);
		chk("row_b", 16'hbeef, rd);
		$display("done rows");
	endtask : t_rows

	// A low enable freezes pins and timers; the read then completes.
	task automatic t_freeze;
		@(negedge clk_in);
		req = '{write: 0, addr: 17'h1f3e0, wdata: 16'h0, be_n: 2'h0};
		req_valid_in = 1;
		wait_hi("ready", req_ready_out);
		@(negedge clk_in);
		req_valid_in = 0;
		ce_in = 0;
		repeat (20) @(negedge clk_in);
		chk("frz_ce", 0, mem_out.ce_n);
		chk("frz_oe", 0, mem_out.oe_n);
		chk("frz_rv", 0, rvalid_out);
		ce_in = 1;
		wait_hi("rvalid", rvalid_out);
		chk("frz_rd", 16'hbeef, rdata_out);
		$display("done freeze");
	endtask : t_freeze

	// Sleep right after a write, then wake and read the word back.
	task automatic t_sleep;
		xfer(1, 17'h00123, 16'hc3c3, 2'h0, lp);
		sleep_req_in = 1;
		wait_hi("asleep", asleep_out);
		chk("zz_pin", 0, mem_out.sleep_request_n);
		chk("dq_oe", 0, dq_oe_out);
		repeat (200) @(negedge clk_in);
		chk("ready_zz", 0, req_ready_out);
		sleep_req_in = 0;
		xfer(0, 17'h00123, 16'h0, 2'h0, lp);
		chk("wake_rd", 16'hc3c3, rd);
		chk("host_err", 0, err);
		$display("done sleep");
	endtask : t_sleep

	initial begin
		repeat (16) @(negedge clk_in);
		sys_rst_in = 0;
		t_reset();
		t_page();
		t_bytes();
		t_rows();
		t_freeze();
		t_sleep();
		close_out();
	end

	// Tests take a few hundred cycles; this is ample.
	initial begin
		repeat (30000) @(posedge clk_in);
		mismatches++;
		close_out();
	end
endmodule : testbench
